// file: include/blc_pkg.sv
// Constants and types for the boost and backlight configuration block
package blc_pkg;
    // Register addresses on the two-wire bus
    localparam logic [7:0] ADDR_CTRL      = 8'h26;
    localparam logic [7:0] ADDR_BOOST_CFG = 8'h27;
    localparam logic [7:0] ADDR_GROUP_CUR = 8'h28;
    localparam logic [7:0] ADDR_CH2_SET   = 8'h29;

    // Values after reset
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_BOOST_CFG = 8'h00;
    localparam logic [7:0] RST_GROUP_CUR = 8'h00;
    localparam logic [7:0] RST_CH2_SET   = 8'h00;

    // Writable bits per register
    localparam logic [7:0] MASK_CTRL      = 8'h23;
    localparam logic [7:0] MASK_BOOST_CFG = 8'hED;
    localparam logic [7:0] MASK_GROUP_CUR = 8'h3F;
    localparam logic [7:0] MASK_CH2_SET   = 8'hBF;

    // Field positions
    localparam int BIT_BOOST_OUT_ON = 5;
    localparam int BIT_CH2_ON       = 1;
    localparam int BIT_GROUP_ON     = 0;
    localparam int BIT_BOOST_MODE   = 7;
    localparam int BIT_BIAS_TARGET  = 6;
    localparam int BIT_FADE_OVR     = 5;
    localparam int OVP_MSB          = 3;
    localparam int OVP_LSB          = 2;
    localparam int BIT_PEAK_LIMIT   = 0;
    localparam int CODE_MSB         = 5;
    localparam int BIT_CH2_GROUP    = 7;

    // Bus address of the device, value arbitrary
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_PTR      = 4'h3,
        ST_W_ACK    = 4'h4,
        ST_WDATA    = 4'h5,
        ST_RDATA    = 4'h6,
        ST_R_ACK    = 4'h7,
        ST_RLOAD    = 4'h8
    } blc_state_type;
endpackage : blc_pkg

// file: verilog/blc_serial_slave.sv
// Two-wire serial slave with register pointer and auto increment
`timescale 1ns/1ns
module blc_serial_slave #(
    parameter logic [6:0] DEV_ADDR = blc_pkg::DEV_ADDR_DEFAULT
) (
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_drive_out,
    input  wire logic [7:0] rd_data_in,
    output logic [7:0]      rd_addr_out,
    output logic            wr_stb_out,
    output logic [7:0]      wr_addr_out,
    output logic [7:0]      wr_data_out
);
    blc_pkg::blc_state_type state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic       drive_q, drive_d;
    logic       rw_q, rw_d;
    logic       scl_prev_q, sda_prev_q;
    logic       stb_q, stb_d;
    logic [7:0] waddr_q, waddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic       scl_rise, scl_fall, start_seen, stop_seen;
    logic [7:0] byte_in;

    assign scl_rise   = scl_in & ~scl_prev_q;
    assign scl_fall   = ~scl_in & scl_prev_q;
    assign start_seen = scl_in & scl_prev_q & sda_prev_q & ~sda_in;
    assign stop_seen  = scl_in & scl_prev_q & ~sda_prev_q & sda_in;
    assign byte_in    = {shift_q[6:0], sda_in};

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        shift_d = shift_q;
        ptr_d   = ptr_q;
        drive_d = drive_q;
        rw_d    = rw_q;
        stb_d   = 1'b0;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        if (start_seen) begin
            state_d = blc_pkg::ST_ADDR;
            cnt_d   = 3'h0;
            drive_d = 1'b0;
        end else if (stop_seen) begin
            state_d = blc_pkg::ST_IDLE;
            drive_d = 1'b0;
        end else begin
            unique case (state_q)
                blc_pkg::ST_IDLE: begin
                end
                blc_pkg::ST_ADDR, blc_pkg::ST_PTR, blc_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_d = byte_in;
                        cnt_d   = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            if (state_q == blc_pkg::ST_PTR) begin
                                ptr_d   = byte_in;
                                state_d = blc_pkg::ST_W_ACK;
                            end else if (state_q == blc_pkg::ST_WDATA) begin
                                stb_d   = 1'b1;
                                waddr_d = ptr_q;
                                wdata_d = byte_in;
                                ptr_d   = ptr_q + 8'h01;
                                state_d = blc_pkg::ST_W_ACK;
                            end else if (byte_in[7:1] == DEV_ADDR) begin
                                rw_d    = byte_in[0];
                                state_d = blc_pkg::ST_ADDR_ACK;
                            end else begin
                                state_d = blc_pkg::ST_IDLE;
                            end
                        end
                    end
                end
                blc_pkg::ST_ADDR_ACK, blc_pkg::ST_W_ACK: begin
                    // First falling edge pulls low, second releases, or after a read address drives the first data bit
                    if (scl_fall) begin
                        drive_d = ~drive_q;
                        if (drive_q) begin
                            cnt_d = 3'h0;
                            if (state_q == blc_pkg::ST_W_ACK) begin
                                state_d = blc_pkg::ST_WDATA;
                            end else if (rw_q) begin
                                shift_d = rd_data_in;
                                drive_d = ~rd_data_in[7];
                                state_d = blc_pkg::ST_RDATA;
                            end else begin
                                state_d = blc_pkg::ST_PTR;
                            end
                        end
                    end
                end
                blc_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            drive_d = 1'b0;
                            state_d = blc_pkg::ST_R_ACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            drive_d = ~shift_q[6];
                        end
                    end
                end
                blc_pkg::ST_R_ACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            state_d = blc_pkg::ST_IDLE;
                        end else begin
                            ptr_d   = ptr_q + 8'h01;
                            state_d = blc_pkg::ST_RLOAD;
                        end
                    end
                end
                blc_pkg::ST_RLOAD: begin
                    if (scl_fall) begin
                        shift_d = rd_data_in;
                        drive_d = ~rd_data_in[7];
                        cnt_d   = 3'h0;
                        state_d = blc_pkg::ST_RDATA;
                    end
                end
                default: begin
                    state_d = blc_pkg::ST_IDLE;
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q    <= blc_pkg::ST_IDLE;
            cnt_q      <= 3'h0;
            shift_q    <= 8'h00;
            ptr_q      <= 8'h00;
            drive_q    <= 1'b0;
            rw_q       <= 1'b0;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            stb_q      <= 1'b0;
            waddr_q    <= 8'h00;
            wdata_q    <= 8'h00;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            ptr_q      <= ptr_d;
            drive_q    <= drive_d;
            rw_q       <= rw_d;
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
            stb_q      <= stb_d;
            waddr_q    <= waddr_d;
            wdata_q    <= wdata_d;
        end
    end

    assign sda_drive_out = drive_q;
    assign rd_addr_out   = ptr_q;
    assign wr_stb_out    = stb_q;
    assign wr_addr_out   = waddr_q;
    assign wr_data_out   = wdata_q;
endmodule : blc_serial_slave

// file: verilog/blc_config.sv
// Boost and LED backlight configuration registers behind the two-wire bus
`timescale 1ns/1ns
module blc_config (
    input  wire logic  clock_in,
    input  wire logic  rst_in,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe_out,
    output logic       boost_standalone_out,
    output logic       boost_output_on_out,
    output logic       boost_bias_target_out,
    output logic       fade_override_out,
    output logic [1:0] boost_overvoltage_level_out,
    output logic       boost_peak_limit_out,
    output logic       sink_channel_one_on_out,
    output logic [5:0] sink_channel_one_code_out,
    output logic       sink_channel_two_grouped_out,
    output logic       sink_channel_two_on_out,
    output logic [5:0] sink_channel_two_code_out
);
    // ****************************************
    // Register bus
    // ****************************************
    logic       wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       drive;

    blc_serial_slave blc_serial_slave_i (
        .clock_in      (clock_in),
        .rst_in        (rst_in),
        .scl_in        (scl_in),
        .sda_in        (sda_in),
        .sda_drive_out (drive),
        .rd_data_in    (rd_data),
        .rd_addr_out   (rd_addr),
        .wr_stb_out    (wr_stb),
        .wr_addr_out   (wr_addr),
        .wr_data_out   (wr_data)
    );

    // Open drain: only ever pulls low
    assign sda_out    = 1'b0;
    assign sda_oe_out = drive;

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] grp_q, grp_d;
    logic [7:0] ch2_q, ch2_d;

    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d  = cfg_q;
        grp_d  = grp_q;
        ch2_d  = ch2_q;
        if (wr_stb) begin
            case (wr_addr)
                blc_pkg::ADDR_CTRL:      ctrl_d = wr_data & blc_pkg::MASK_CTRL;
                blc_pkg::ADDR_BOOST_CFG: cfg_d  = wr_data & blc_pkg::MASK_BOOST_CFG;
                blc_pkg::ADDR_GROUP_CUR: grp_d  = wr_data & blc_pkg::MASK_GROUP_CUR;
                blc_pkg::ADDR_CH2_SET:   ch2_d  = wr_data & blc_pkg::MASK_CH2_SET;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ctrl_q <= blc_pkg::RST_CTRL;
            cfg_q  <= blc_pkg::RST_BOOST_CFG;
            grp_q  <= blc_pkg::RST_GROUP_CUR;
            ch2_q  <= blc_pkg::RST_CH2_SET;
        end else begin
            ctrl_q <= ctrl_d;
            cfg_q  <= cfg_d;
            grp_q  <= grp_d;
            ch2_q  <= ch2_d;
        end
    end

    // Read back; unmapped addresses answer zero
    always_comb begin
        case (rd_addr)
            blc_pkg::ADDR_CTRL:      rd_data = ctrl_q;
            blc_pkg::ADDR_BOOST_CFG: rd_data = cfg_q;
            blc_pkg::ADDR_GROUP_CUR: rd_data = grp_q;
            blc_pkg::ADDR_CH2_SET:   rd_data = ch2_q;
            default:                 rd_data = 8'h00;
        endcase
    end

    // ****************************************
    // Effective settings
    // ****************************************
    logic       stand_q, stand_d;
    logic       bst_on_q, bst_on_d;
    logic       bias_q, bias_d;
    logic       fade_q, fade_d;
    logic [1:0] ovp_q, ovp_d;
    logic       peak_q, peak_d;
    logic       s1_on_q, s1_on_d;
    logic [5:0] s1_code_q, s1_code_d;
    logic       s2_grp_q, s2_grp_d;
    logic       s2_on_q, s2_on_d;
    logic [5:0] s2_code_q, s2_code_d;

    always_comb begin
        stand_d   = cfg_q[blc_pkg::BIT_BOOST_MODE];
        bst_on_d  = stand_d & ctrl_q[blc_pkg::BIT_BOOST_OUT_ON];
        bias_d    = ~stand_d & cfg_q[blc_pkg::BIT_BIAS_TARGET];
        fade_d    = cfg_q[blc_pkg::BIT_FADE_OVR];
        ovp_d     = cfg_q[blc_pkg::OVP_MSB:blc_pkg::OVP_LSB];
        peak_d    = cfg_q[blc_pkg::BIT_PEAK_LIMIT];
        s1_on_d   = ctrl_q[blc_pkg::BIT_GROUP_ON];
        s1_code_d = grp_q[blc_pkg::CODE_MSB:0];
        s2_grp_d  = ch2_q[blc_pkg::BIT_CH2_GROUP];
        if (s2_grp_d) begin
            s2_on_d   = ctrl_q[blc_pkg::BIT_GROUP_ON];
            s2_code_d = grp_q[blc_pkg::CODE_MSB:0];
        end else begin
            s2_on_d   = ctrl_q[blc_pkg::BIT_CH2_ON];
            s2_code_d = ch2_q[blc_pkg::CODE_MSB:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            stand_q   <= 1'b0;
            bst_on_q  <= 1'b0;
            bias_q    <= 1'b0;
            fade_q    <= 1'b0;
            ovp_q     <= 2'h0;
            peak_q    <= 1'b0;
            s1_on_q   <= 1'b0;
            s1_code_q <= 6'h00;
            s2_grp_q  <= 1'b0;
            s2_on_q   <= 1'b0;
            s2_code_q <= 6'h00;
        end else begin
            stand_q   <= stand_d;
            bst_on_q  <= bst_on_d;
            bias_q    <= bias_d;
            fade_q    <= fade_d;
            ovp_q     <= ovp_d;
            peak_q    <= peak_d;
            s1_on_q   <= s1_on_d;
            s1_code_q <= s1_code_d;
            s2_grp_q  <= s2_grp_d;
            s2_on_q   <= s2_on_d;
            s2_code_q <= s2_code_d;
        end
    end

    assign boost_standalone_out         = stand_q;
    assign boost_output_on_out          = bst_on_q;
    assign boost_bias_target_out        = bias_q;
    assign fade_override_out            = fade_q;
    assign boost_overvoltage_level_out  = ovp_q;
    assign boost_peak_limit_out         = peak_q;
    assign sink_channel_one_on_out      = s1_on_q;
    assign sink_channel_one_code_out    = s1_code_q;
    assign sink_channel_two_grouped_out = s2_grp_q;
    assign sink_channel_two_on_out      = s2_on_q;
    assign sink_channel_two_code_out    = s2_code_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);

    group_enable_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_CTRL |-> ##2 sink_channel_one_on_out == $past(wr_data[0], 2))
        else $error("grouped enable not applied");

    boost_mode_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG |-> ##2 boost_standalone_out == $past(wr_data[7], 2))
        else $error("boost mode not applied");

    bias_target_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG && !wr_data[7]
        |-> ##2 boost_bias_target_out == $past(wr_data[6], 2))
        else $error("bias target not applied");

    bias_ignored_a: assert property (
        boost_standalone_out |-> !boost_bias_target_out)
        else $error("bias target active in standalone boost");

    fade_override_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG |-> ##2 fade_override_out == $past(wr_data[5], 2))
        else $error("fade override not applied");

    ovp_level_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG
        |-> ##2 boost_overvoltage_level_out == $past(wr_data[3:2], 2))
        else $error("overvoltage level not applied");

    peak_limit_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG |-> ##2 boost_peak_limit_out == $past(wr_data[0], 2))
        else $error("peak limit not applied");

    group_code_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_GROUP_CUR
        |-> ##2 sink_channel_one_code_out == $past(wr_data[5:0], 2))
        else $error("grouped code not applied");

    code_reset_a: assert property (
        $past(rst_in) |-> grp_q == 8'h00 && ch2_q == 8'h00)
        else $error("current codes not zero after reset");

    ch2_select_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_CH2_SET
        |-> ##2 sink_channel_two_grouped_out == $past(wr_data[7], 2))
        else $error("channel two group select not applied");

    ch2_own_code_a: assert property (
        !s2_grp_q |-> s2_code_q == $past(ch2_q[5:0]) || $past(ch2_q[7]))
        else $error("channel two own code not followed");

    boost_enable_a: assert property (
        boost_output_on_out |-> boost_standalone_out)
        else $error("boost output on outside standalone boost");

    ch2_enable_a: assert property (
        $past(ch2_q[7]) |-> s2_on_q == $past(ctrl_q[0]))
        else $error("channel two own enable used while grouped");

    unused_zero_a: assert property (
        (cfg_q & ~blc_pkg::MASK_BOOST_CFG) == 8'h00 && (ch2_q & ~blc_pkg::MASK_CH2_SET) == 8'h00
        && (grp_q & ~blc_pkg::MASK_GROUP_CUR) == 8'h00 && (ctrl_q & ~blc_pkg::MASK_CTRL) == 8'h00)
        else $error("unused bit holds a one");

    ch2_grouped_a: assert property (
        sink_channel_two_grouped_out && $stable(grp_q) && $past(ch2_q[7])
        |-> sink_channel_two_code_out == sink_channel_one_code_out)
        else $error("grouped channel two not on grouped code");

    ctrl_write_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_CTRL |=> ctrl_q == ($past(wr_data) & blc_pkg::MASK_CTRL))
        else $error("control write not masked");

    cfg_write_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_BOOST_CFG |=> cfg_q == ($past(wr_data) & blc_pkg::MASK_BOOST_CFG))
        else $error("boost configuration write not masked");

    grp_write_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_GROUP_CUR |=> grp_q == ($past(wr_data) & blc_pkg::MASK_GROUP_CUR))
        else $error("grouped code write not masked");

    ch2_write_a: assert property (
        wr_stb && wr_addr == blc_pkg::ADDR_CH2_SET |=> ch2_q == ($past(wr_data) & blc_pkg::MASK_CH2_SET))
        else $error("channel two write not masked");

    regs_hold_a: assert property (
        !wr_stb |=> $stable(ctrl_q) && $stable(cfg_q) && $stable(grp_q) && $stable(ch2_q))
        else $error("register changed without a write");

    unmapped_zero_a: assert property (
        rd_addr != blc_pkg::ADDR_CTRL && rd_addr != blc_pkg::ADDR_BOOST_CFG && rd_addr != blc_pkg::ADDR_GROUP_CUR
        && rd_addr != blc_pkg::ADDR_CH2_SET |-> rd_data == 8'h00)
        else $error("unmapped address read not zero");

    ch2_own_enable_a: assert property (
        !$past(ch2_q[7]) |-> s2_on_q == $past(ctrl_q[blc_pkg::BIT_CH2_ON]))
        else $error("channel two own enable not followed");

    reset_values_a: assert property (
        $past(rst_in) |-> ctrl_q == blc_pkg::RST_CTRL && cfg_q == blc_pkg::RST_BOOST_CFG)
        else $error("control or boost configuration not reset");

    outputs_reset_a: assert property (
        $past(rst_in) |-> sink_channel_one_code_out == 6'h00 && sink_channel_two_code_out == 6'h00
        && !sink_channel_one_on_out && !sink_channel_two_on_out && !boost_output_on_out)
        else $error("sink outputs not quiet after reset");

    cfg_reset_out_a: assert property (
        $past(rst_in) |-> !boost_standalone_out && !fade_override_out && !boost_peak_limit_out
        && boost_overvoltage_level_out == 2'h0 && !sink_channel_two_grouped_out)
        else $error("configuration outputs not at reset values");

    group_enable_follow_a: assert property (
        sink_channel_two_grouped_out |-> sink_channel_two_on_out == sink_channel_one_on_out)
        else $error("grouped channel two not on grouped enable");
endmodule : blc_config

// file: bench/blc_config_test.sv
// Testbench for the boost and backlight configuration registers over the two-wire bus
`timescale 1ns/1ns
module blc_config_test;
    logic       clock_in;
    logic       rst_in;
    logic       scl;
    logic       sda_m;
    wire logic  sda_line;
    logic       sda_out;
    logic       sda_oe_out;
    logic       standalone;
    logic       boost_on;
    logic       bias;
    logic       fade;
    logic [1:0] ovp;
    logic       peak;
    logic       ch1_on;
    logic [5:0] ch1_code;
    logic       ch2_grouped;
    logic       ch2_on;
    logic [5:0] ch2_code;
    logic [7:0] v;
    logic       k;
    int         fails;
    int         checks_done;

    // Open drain wire with pull-up
    assign sda_line = sda_m & (sda_oe_out ? sda_out : 1'b1);

    blc_config blc_config_i (
        .clock_in                     (clock_in),
        .rst_in                       (rst_in),
        .scl_in                       (scl),
        .sda_in                       (sda_line),
        .sda_out                      (sda_out),
        .sda_oe_out                   (sda_oe_out),
        .boost_standalone_out         (standalone),
        .boost_output_on_out          (boost_on),
        .boost_bias_target_out        (bias),
        .fade_override_out            (fade),
        .boost_overvoltage_level_out  (ovp),
        .boost_peak_limit_out         (peak),
        .sink_channel_one_on_out      (ch1_on),
        .sink_channel_one_code_out    (ch1_code),
        .sink_channel_two_grouped_out (ch2_grouped),
        .sink_channel_two_on_out      (ch2_on),
        .sink_channel_two_code_out    (ch2_code)
    );

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic ticks(input int n);
        repeat (n) @(posedge clock_in);
    endtask : ticks

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic put_bit(input logic b, output logic seen);
        ticks(3);
        sda_m <= b;
        ticks(3);
        scl <= 1'b1;
        ticks(2);
        seen = sda_line;
        ticks(2);
        scl <= 1'b0;
    endtask : put_bit

    task automatic start_c;
        ticks(3);
        sda_m <= 1'b1;
        ticks(3);
        scl <= 1'b1;
        ticks(4);
        sda_m <= 1'b0;
        ticks(4);
        scl <= 1'b0;
    endtask : start_c

    task automatic stop_c;
        ticks(3);
        sda_m <= 1'b0;
        ticks(3);
        scl <= 1'b1;
        ticks(4);
        sda_m <= 1'b1;
        ticks(4);
    endtask : stop_c

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, ack);
    endtask : send_byte

    task automatic put_byte(input logic [7:0] d);
        logic ack;
        send_byte(d, ack);
        check(8'(ack), 8'h00);
    endtask : put_byte

    // Last low means master acknowledge, so the pointer moves on
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(last, s);
    endtask : get_byte

    task automatic wr_open(input logic [7:0] a);
        start_c();
        put_byte({blc_pkg::DEV_ADDR_DEFAULT, 1'b0});
        put_byte(a);
    endtask : wr_open

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_open(a);
        put_byte(d);
        stop_c();
    endtask : wr

    task automatic rd_open(input logic [7:0] a);
        wr_open(a);
        start_c();
        put_byte({blc_pkg::DEV_ADDR_DEFAULT, 1'b1});
    endtask : rd_open

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_open(a);
        get_byte(1'b1, d);
        stop_c();
    endtask : rd

    task automatic conclude;
        if (fails == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        fails = 0;
        checks_done = 0;
        rst_in = 1'b1;
        scl = 1'b1;
        sda_m = 1'b1;
        ticks(10);
        rst_in <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(8'h26 + 8'(i), v); check(v, 8'h00);
        end
        wr(blc_pkg::ADDR_BOOST_CFG, 8'hFF);
        rd(blc_pkg::ADDR_BOOST_CFG, v); check(v, 8'hED);
        check(8'(standalone), 8'h01);
        check(8'(bias), 8'h00);
        check(8'(fade), 8'h01);
        check(8'(ovp), 8'h03);
        check(8'(peak), 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(blc_pkg::ADDR_BOOST_CFG, 8'h40 | 8'(i << 2));
            check(8'(ovp), 8'(i));
            check(8'(bias), 8'h01);
            check(8'(standalone), 8'h00);
            check(8'({fade, peak}), 8'h00);
        end
        wr(blc_pkg::ADDR_CTRL, 8'hFF);
        rd(blc_pkg::ADDR_CTRL, v); check(v, 8'h23);
        check(8'(boost_on), 8'h00);
        wr(blc_pkg::ADDR_BOOST_CFG, 8'h80);
        check(8'(boost_on), 8'h01);
        wr(blc_pkg::ADDR_GROUP_CUR, 8'hFF);
        rd(blc_pkg::ADDR_GROUP_CUR, v); check(v, 8'h3F);
        check(8'(ch1_code), 8'h3F);
        check(8'(ch1_on), 8'h01);
        wr(blc_pkg::ADDR_CH2_SET, 8'h55);
        rd(blc_pkg::ADDR_CH2_SET, v); check(v, 8'h15);
        check(8'({ch2_grouped, ch2_on}), 8'h01);
        check(8'(ch2_code), 8'h15);
        wr(blc_pkg::ADDR_CTRL, 8'h01);
        check(8'(ch2_on), 8'h00);
        wr(blc_pkg::ADDR_CH2_SET, 8'hD5);
        rd(blc_pkg::ADDR_CH2_SET, v); check(v, 8'h95);
        check(8'({ch2_grouped, ch2_on}), 8'h03);
        check(8'(ch2_code), 8'h3F);
        wr(blc_pkg::ADDR_CTRL, 8'h02);
        check(8'({ch1_on, ch2_on}), 8'h00);
        wr(8'h30, 8'hAA);
        rd(8'h30, v); check(v, 8'h00);
        // Burst write and burst read across two registers
        wr_open(blc_pkg::ADDR_GROUP_CUR);
        put_byte(8'h2A);
        put_byte(8'h47);
        stop_c();
        check(8'({ch2_grouped, ch2_on}), 8'h01);
        check(8'(ch2_code), 8'h07);
        check(8'(ch1_code), 8'h2A);
        rd_open(blc_pkg::ADDR_GROUP_CUR);
        get_byte(1'b0, v);
        check(v, 8'h2A);
        get_byte(1'b1, v);
        check(v, 8'h07);
        stop_c();
        // Foreign device address is not answered
        start_c();
        send_byte({blc_pkg::DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, k);
        check(8'(k), 8'h01);
        stop_c();
        rst_in <= 1'b1;
        ticks(2);
        rst_in <= 1'b0;
        rd(blc_pkg::ADDR_BOOST_CFG, v); check(v, 8'h00);
        check(8'({standalone, ch2_grouped, ch1_code}), 8'h00);
        conclude();
    end
endmodule : blc_config_test
